// File: rtl/ssr_pkg.sv
// Purpose: shared constants and types of the standstill release monitor
// Assumes: 250 MHz system clock, 32-bit APB register bus
// Notes: frequencies are in 0.01 Hz units, hysteresis in whole percent
package ssr_pkg;
	localparam longint unsigned CLK_HZ = 250_000_000;
	localparam longint unsigned T_DEB_SHORT_MS = 100;
	localparam longint unsigned T_DEB_LONG_MS = 350;
	localparam longint unsigned T_PULSE_MAX_S = 30;
	localparam longint unsigned T_BLINK_HALF_MS = 500;
	localparam longint unsigned T_OVR_LIMIT_S = 1;
	localparam longint unsigned DEB_SHORT_CYC = CLK_HZ * T_DEB_SHORT_MS / 1000;
	localparam longint unsigned DEB_LONG_CYC = CLK_HZ * T_DEB_LONG_MS / 1000;
	localparam longint unsigned PULSE_MAX_CYC = CLK_HZ * T_PULSE_MAX_S;
	localparam longint unsigned BLINK_HALF_CYC = CLK_HZ * T_BLINK_HALF_MS / 1000;
	localparam longint unsigned OVR_LIMIT_CYC = CLK_HZ * T_OVR_LIMIT_S;
	localparam int CNT_W = 34;
	localparam int FREQ_W = 20;
	localparam int FMAX_W = 14;
	localparam int HYST_W = 7;
	localparam int CMP_W = 28;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FMAX = 8'h04;
	localparam logic [7:0] ADDR_HYST = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam int CTRL_MANUAL = 0;
	localparam int CTRL_USE_RESET = 1;
	localparam int CTRL_OVR_LO = 2;
	localparam int CTRL_LIMIT_EN = 4;
	localparam int CTRL_DEB_LONG = 5;
	localparam int CTRL_W = 6;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h13;
	localparam logic [FMAX_W-1:0] FMAX_RESET = 14'h0064;
	localparam logic [FMAX_W-1:0] FMAX_LOW = 14'h000A;
	localparam logic [FMAX_W-1:0] FMAX_HIGH = 14'h26AC;
	localparam logic [HYST_W-1:0] HYST_RESET = 7'h0A;
	localparam logic [HYST_W-1:0] HYST_HIGH = 7'h32;
	localparam logic [HYST_W-1:0] PCT_FULL = 7'h64;
	localparam int ST_REL = 0;
	localparam int ST_RST_REQ = 1;
	localparam int ST_RES_REQ = 2;
	localparam int ST_OVR = 3;
	localparam int ST_ERR_LO = 4;
	localparam int ST_VIB = 7;
	localparam int ST_PHASE = 8;
	localparam int ST_STATE_LO = 9;
	typedef enum logic [1:0] {
		ST_BLOCKED = 2'b00,
		ST_WAIT = 2'b01,
		ST_RELEASED = 2'b10
	} ssr_state_t;
	typedef enum logic [1:0] {
		OVR_OFF = 2'b00,
		OVR_COND = 2'b01,
		OVR_UNCOND = 2'b10
	} ssr_ovr_mode_t;
	typedef struct packed {
		logic cutoff;
		logic sensor;
		logic disc;
	} ssr_err_t;
endpackage

// File: rtl/ssr_monitor.sv
// Purpose: standstill release monitor with restart lock, error reset and override
// Assumes: frequency and error events come from same-clock logic; pins are asynchronous
// Notes: registers on APB, one wait state per access
// How it works
// - override input counts as asserted while high
// - outside override, release low while any error or no valid frequency sample
// - restart request blinks 1 Hz while manual restart is awaited
// - separate latched outputs for cut-off, sensor and discrepancy errors
// - withdraw release at f >= fmax, grant again only below fmin
// - fmax set from 0.1 Hz to 99 Hz in 0.01 Hz steps
// - hysteresis selectable from 0 to 50 percent
// - over-threshold check acts on every frequency sample within one cycle
// - outside override, manual mode never raises release before a valid restart pulse
// - restart request stays until low-high-low pulse, release on falling edge
// - automatic mode releases at once, restart pin and request unused
// - error without override forces release low, override keeps it high
// - reset request blinks 1 Hz after error until reset pulse falls
// - reset during override clears only errors and reset request
// - reset without override returns block to power-up state
// - conditional override starts on rising edge only while released
// - unconditional override starts on every rising edge
// - optional 1 s time limit forcibly ends the override
// - a level already high at start-up never starts override
// - override end clears errors then re-evaluates release
// - no new restart lock during override, confirmations survive it
// - errors latch until reset or override end, warnings follow cause
`timescale 1ns/1ps

module ssr_pulse_chk #(
	parameter longint unsigned MAX_CYC = 1
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic level,
	input wire logic [ssr_pkg::CNT_W-1:0] deb_cyc,
	output logic pulse
);
	import ssr_pkg::*;
	logic prev;
	logic [CNT_W-1:0] cnt;
	wire logic fell = prev & ~level;
	// saturate so a stuck-high pin can never wrap into a valid length
	wire logic sat = (cnt == {CNT_W{1'b1}});
	wire logic len_ok = (cnt > deb_cyc) && (cnt <= CNT_W'(MAX_CYC));

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prev <= 1'b0;
			cnt <= '0;
			pulse <= 1'b0;
		end else begin
			prev <= level;
			cnt <= level ? (sat ? cnt : cnt + 1'b1) : '0;
			pulse <= fell & len_ok;
		end
	end
endmodule // ssr_pulse_chk

module ssr_monitor #(
	parameter longint unsigned DEB_SHORT = ssr_pkg::DEB_SHORT_CYC,
	parameter longint unsigned DEB_LONG = ssr_pkg::DEB_LONG_CYC,
	parameter longint unsigned PULSE_MAX = ssr_pkg::PULSE_MAX_CYC,
	parameter longint unsigned BLINK_HALF = ssr_pkg::BLINK_HALF_CYC,
	parameter longint unsigned OVR_LIMIT = ssr_pkg::OVR_LIMIT_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [ssr_pkg::FREQ_W-1:0] freq_meas,
	input wire logic freq_valid,
	input wire ssr_pkg::ssr_err_t err_evt,
	input wire logic warn_vib_in,
	input wire logic warn_phase_in,
	input wire logic restart_pin,
	input wire logic reset_pin,
	input wire logic override_pin,
	output logic release_out,
	output logic restart_req,
	output logic reset_req,
	output ssr_pkg::ssr_err_t err_flags,
	output logic warn_vib,
	output logic warn_phase,
	output logic override_active
);
	import ssr_pkg::*;

	logic [CTRL_W-1:0] ctrl;
	logic [FMAX_W-1:0] fmax;
	logic [HYST_W-1:0] hyst;
	ssr_state_t state;
	ssr_state_t next_state;
	logic restart_ok;
	logic [1:0] rs_sync, rt_sync, ov_sync;
	logic ov_prev;
	logic [CNT_W-1:0] blink_cnt;
	logic blink_ph;
	logic [CNT_W-1:0] ovr_cnt;
	logic restart_pulse, reset_pulse;

	// configuration fields
	wire logic manual = ctrl[CTRL_MANUAL];
	wire logic use_reset = ctrl[CTRL_USE_RESET];
	wire logic [1:0] ovr_mode = ctrl[CTRL_OVR_LO +: 2];
	wire logic lim_en = ctrl[CTRL_LIMIT_EN];
	wire logic [CNT_W-1:0] deb_cyc = ctrl[CTRL_DEB_LONG] ? CNT_W'(DEB_LONG) : CNT_W'(DEB_SHORT);

	// threshold compare, fmin scaled by 100 to avoid a divider
	wire logic [CMP_W-1:0] f_x100 = CMP_W'(freq_meas) * CMP_W'(PCT_FULL);
	wire logic [CMP_W-1:0] fmin_x100 = CMP_W'(fmax) * CMP_W'(PCT_FULL - hyst);
	wire logic below_min = freq_valid & (f_x100 < fmin_x100);
	wire logic at_max = ~freq_valid | (CMP_W'(freq_meas) >= CMP_W'(fmax));

	// error latching and clear sources
	wire logic [2:0] err_v = err_flags;
	wire logic [2:0] evt_v = err_evt;
	wire logic err_any = |err_v;
	wire logic ov_rise = ov_sync[1] & ~ov_prev;
	wire logic ov_fall = ~ov_sync[1] & ov_prev;
	wire logic lim_hit = lim_en & (ovr_cnt == CNT_W'(OVR_LIMIT - 1));
	wire logic ovr_start = ov_rise & ~override_active
		& ((ovr_mode == OVR_UNCOND) | ((ovr_mode == OVR_COND) & release_out));
	wire logic ovr_end = override_active
		& (ov_fall | lim_hit | (ovr_mode == OVR_OFF) | (ovr_mode == 2'b11));
	wire logic rst_take = reset_pulse & use_reset;
	wire logic full_init = rst_take & ~override_active;
	wire logic err_clr = rst_take | ovr_end;
	// a new event wins over a clear in the same cycle
	wire logic [2:0] next_err = evt_v | (err_v & ~{3{err_clr}});

	// release path
	wire logic rel_ok = (state == ST_RELEASED) & ~err_any & ~at_max;
	wire logic next_release = override_active | rel_ok;

	always_comb begin
		next_state = state;
		unique case (state)
			ST_BLOCKED: begin
				// during override no new lock is armed; a prior confirmation still counts
				if (below_min & ~err_any & ~override_active) begin
					if (~manual | restart_ok) begin
						next_state = ST_RELEASED;
					end else begin
						next_state = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				if (~manual) begin
					next_state = ST_BLOCKED;
				end else if (restart_pulse & ~at_max & ~err_any) begin
					next_state = ST_RELEASED;
				end else if (at_max | err_any) begin
					next_state = ST_BLOCKED;
				end
			end
			ST_RELEASED: begin
				if (at_max | err_any) begin
					next_state = ST_BLOCKED;
				end
			end
			default: begin
				next_state = ST_BLOCKED;
			end
		endcase
	end

	// pin synchronisers; override idles high so a high level at start-up is no edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rs_sync <= 2'b00;
			rt_sync <= 2'b00;
			ov_sync <= 2'b11;
			ov_prev <= 1'b1;
		end else begin
			rs_sync <= {rs_sync[0], restart_pin};
			rt_sync <= {rt_sync[0], reset_pin};
			ov_sync <= {ov_sync[0], override_pin};
			ov_prev <= ov_sync[1];
		end
	end

	ssr_pulse_chk #(.MAX_CYC(PULSE_MAX)) u_restart_chk (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.level(rs_sync[1]),
		.deb_cyc(deb_cyc),
		.pulse(restart_pulse)
	);

	ssr_pulse_chk #(.MAX_CYC(PULSE_MAX)) u_reset_chk (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.level(rt_sync[1]),
		.deb_cyc(deb_cyc),
		.pulse(reset_pulse)
	);

	// 1 Hz blink shared by both request indicators
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			blink_cnt <= '0;
			blink_ph <= 1'b1;
		end else if (blink_cnt == CNT_W'(BLINK_HALF - 1)) begin
			blink_cnt <= '0;
			blink_ph <= ~blink_ph;
		end else begin
			blink_cnt <= blink_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			override_active <= 1'b0;
			ovr_cnt <= '0;
		end else if (ovr_start) begin
			override_active <= 1'b1;
			ovr_cnt <= '0;
		end else if (ovr_end) begin
			override_active <= 1'b0;
			ovr_cnt <= '0;
		end else if (override_active) begin
			ovr_cnt <= ovr_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_BLOCKED;
			restart_ok <= 1'b0;
			err_flags <= '0;
		end else if (full_init) begin
			state <= ST_BLOCKED;
			restart_ok <= 1'b0;
			err_flags <= ssr_err_t'(evt_v);
		end else begin
			state <= next_state;
			err_flags <= ssr_err_t'(next_err);
			if (restart_pulse & manual & (state == ST_WAIT)) begin
				restart_ok <= 1'b1;
			end else if ((state == ST_RELEASED) & (next_state == ST_BLOCKED)
				& ~override_active) begin
				restart_ok <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			release_out <= 1'b0;
			restart_req <= 1'b0;
			reset_req <= 1'b0;
			warn_vib <= 1'b0;
			warn_phase <= 1'b0;
		end else begin
			release_out <= next_release;
			restart_req <= manual & (state == ST_WAIT) & blink_ph;
			reset_req <= use_reset & err_any & ~err_clr & blink_ph;
			warn_vib <= warn_vib_in;
			warn_phase <= warn_phase_in;
		end
	end

	// APB slave: one wait state, write lands at the completing edge
	wire logic acc = psel & penable & ~pready;
	wire logic done = psel & penable & pready;
	wire logic hit_ctrl = (paddr == ADDR_CTRL);
	wire logic hit_fmax = (paddr == ADDR_FMAX);
	wire logic hit_hyst = (paddr == ADDR_HYST);
	wire logic hit_stat = (paddr == ADDR_STATUS);
	wire logic hit_any = hit_ctrl | hit_fmax | hit_hyst | hit_stat;
	wire logic wr_bad = pwrite & hit_stat;
	// out-of-range settings are clamped rather than refused
	wire logic [FMAX_W-1:0] wr_fmax = (pwdata[FMAX_W-1:0] < FMAX_LOW) ? FMAX_LOW
		: (pwdata[FMAX_W-1:0] > FMAX_HIGH) ? FMAX_HIGH : pwdata[FMAX_W-1:0];
	wire logic [HYST_W-1:0] wr_hyst = (pwdata[HYST_W-1:0] > HYST_HIGH) ? HYST_HIGH
		: pwdata[HYST_W-1:0];
	wire logic [31:0] status_word = 32'(release_out) << ST_REL
		| 32'(state == ST_WAIT) << ST_RST_REQ
		| 32'(err_any) << ST_RES_REQ
		| 32'(override_active) << ST_OVR
		| 32'(err_v) << ST_ERR_LO
		| 32'(warn_vib) << ST_VIB
		| 32'(warn_phase) << ST_PHASE
		| 32'(state) << ST_STATE_LO;
	wire logic [31:0] rd_word = hit_ctrl ? 32'(ctrl) : hit_fmax ? 32'(fmax)
		: hit_hyst ? 32'(hyst) : hit_stat ? status_word : 32'h0000_0000;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= acc;
			pslverr <= acc & (~hit_any | wr_bad);
			prdata <= (acc & ~pwrite) ? rd_word : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= CTRL_RESET;
			fmax <= FMAX_RESET;
			hyst <= HYST_RESET;
		end else if (done & pwrite) begin
			if (hit_ctrl) begin
				ctrl <= pwdata[CTRL_W-1:0];
			end
			if (hit_fmax) begin
				fmax <= wr_fmax;
			end
			if (hit_hyst) begin
				hyst <= wr_hyst;
			end
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_error_forces_low: assert property ((err_any && !override_active) |=> !release_out)
		else $error("release high while error latched");
	a_invalid_data_low: assert property ((!freq_valid && !override_active) |=> !release_out)
		else $error("release high without valid frequency");
	a_override_holds: assert property (override_active |=> release_out)
		else $error("release low during override");
	a_fmax_withdraws: assert property ((at_max && !override_active) |=> !release_out)
		else $error("release kept at or above fmax");
	a_manual_wait_low: assert property ((manual && state == ST_WAIT && !override_active)
		|=> !release_out)
		else $error("release before restart pulse");
	a_auto_no_request: assert property ((!manual) ##1 (!manual) |=> !restart_req)
		else $error("restart request in automatic mode");
	a_override_on_edge: assert property ($rose(override_active) |-> $past(ov_rise))
		else $error("override started without rising edge");
	a_cond_needs_rel: assert property ((ov_rise && !override_active && ovr_mode == OVR_COND
		&& !release_out) |=> !override_active)
		else $error("conditional override without release");
	a_end_clears_err: assert property (ovr_end |=> (err_v == $past(evt_v)))
		else $error("errors kept after override end");
	a_limit_ends: assert property ((override_active && lim_hit && !ovr_start)
		|=> !override_active)
		else $error("override outlived its time limit");
	a_reset_req_cause: assert property (reset_req |-> $past(err_any && use_reset))
		else $error("reset request without error");
	a_full_init_state: assert property (full_init |=> (state == ST_BLOCKED && !restart_ok))
		else $error("reset did not return to initial state");
	a_uncond_starts: assert property (
		(ov_rise && !override_active && ovr_mode == OVR_UNCOND) |=> override_active)
		else $error("bypass did not start on rising edge");
	a_fall_ends: assert property ((override_active && ov_fall) |=> !override_active)
		else $error("override kept after falling edge");
	a_reset_in_bypass: assert property (
		(rst_take && override_active && !ovr_end)
		|=> (override_active && err_v == $past(evt_v)))
		else $error("reset in bypass ended bypass or kept errors");
	a_restart_grants: assert property (
		(manual && state == ST_WAIT && restart_pulse && !at_max && !err_any && !full_init)
		|=> (state == ST_RELEASED))
		else $error("restart pulse did not grant release");
	a_auto_releases: assert property (
		(!manual && state == ST_BLOCKED && below_min && !err_any
		&& !override_active && !full_init) |=> (state == ST_RELEASED))
		else $error("automatic mode did not release");
endmodule // ssr_monitor

// File: verification/ssr_field_model.sv
// Purpose: sensor front end and supervisory controller driving the monitor inputs
// Assumes: same clock as the monitor, short debounce of 8 cycles in simulation
// Notes: pins change only right after a rising edge
`timescale 1ns/1ps

module ssr_field_model #(
	parameter int HI_CYC = 12
) (
	input wire logic clk_sys,
	output logic [ssr_pkg::FREQ_W-1:0] freq_meas,
	output logic freq_valid,
	output ssr_pkg::ssr_err_t err_evt,
	output logic restart_pin,
	output logic reset_pin,
	output logic override_pin
);
	import ssr_pkg::*;
	logic [FREQ_W-1:0] f_now;
	logic valid_now;
	// stale data is inverted so it never passes for a fresh sample
	assign freq_meas = valid_now ? f_now : ~f_now;
	assign freq_valid = valid_now;
	initial begin
		f_now = '0;
		valid_now = 1'b0;
		err_evt = '0;
		restart_pin = 1'b0;
		reset_pin = 1'b0;
		override_pin = 1'b1;
	end
	task automatic set_freq(input logic [FREQ_W-1:0] f, input logic v);
		@(posedge clk_sys);
		f_now <= f;
		valid_now <= v;
	endtask
	task automatic set_ovr(input logic v);
		@(posedge clk_sys);
		override_pin <= v;
	endtask
	task automatic err_pulse(input ssr_err_t e);
		@(posedge clk_sys);
		err_evt <= e;
		@(posedge clk_sys);
		err_evt <= '0;
	endtask
	// high time above the short debounce but below the long one, and far below the upper limit
	task automatic pulse(input logic is_reset);
		@(posedge clk_sys);
		if (is_reset) reset_pin <= 1'b1;
		else restart_pin <= 1'b1;
		repeat (HI_CYC) @(posedge clk_sys);
		reset_pin <= 1'b0;
		restart_pin <= 1'b0;
	endtask
endmodule // ssr_field_model

// File: verification/tb_ssr_monitor.sv
// Purpose: register and behaviour tests of the standstill release monitor
// Assumes: shortened counts, debounce 8, blink half 10, override limit 50 cycles
// Notes: waits after pins follow the fixed latencies of the monitor
`timescale 1ns/1ps

module tb_ssr_monitor;
	import ssr_pkg::*;
	logic clk_sys;
	logic rst_n;
	logic psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, warn_vib_in, warn_phase_in;
	logic [FREQ_W-1:0] freq_meas;
	logic freq_valid, restart_pin, reset_pin, override_pin;
	logic release_out, restart_req, reset_req, warn_vib, warn_phase, override_active;
	ssr_err_t err_evt, err_flags;
	logic [31:0] n;
	int mismatches = 0;
	int n_tests = 0;
	always #2 clk_sys = ~clk_sys;
	ssr_monitor #(.DEB_SHORT(8), .DEB_LONG(16), .PULSE_MAX(200), .BLINK_HALF(10),
		.OVR_LIMIT(50)) ssr_monitor_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .freq_meas(freq_meas),
		.freq_valid(freq_valid), .err_evt(err_evt), .warn_vib_in(warn_vib_in),
		.warn_phase_in(warn_phase_in), .restart_pin(restart_pin), .reset_pin(reset_pin),
		.override_pin(override_pin), .release_out(release_out), .restart_req(restart_req),
		.reset_req(reset_req), .err_flags(err_flags), .warn_vib(warn_vib),
		.warn_phase(warn_phase), .override_active(override_active));
	ssr_field_model ssr_field_model_i (.clk_sys(clk_sys), .freq_meas(freq_meas),
		.freq_valid(freq_valid), .err_evt(err_evt), .restart_pin(restart_pin),
		.reset_pin(reset_pin), .override_pin(override_pin));
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int i;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			mismatches++;
			finish_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
		logic [31:0] rd;
		logic err;
		apb(1'b1, a, d, rd, err);
		check(err, exp_err, "write response");
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
		logic [31:0] v;
		logic err;
		apb(1'b0, a, 32'h0, v, err);
		check(err, exp_err, "read response");
		check(v, exp, "read data");
	endtask
	// a 20 cycle window holds exactly one blink period whatever the phase
	task automatic count_blink(input logic use_reset_req, output logic [31:0] cnt);
		cnt = '0;
		repeat (20) begin
			@(posedge clk_sys);
			cnt += use_reset_req ? reset_req : restart_req;
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
	endtask
	initial begin
		clk_sys = 1'b0;
		rst_n <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0000_0000;
		warn_vib_in <= 1'b0;
		warn_phase_in <= 1'b0;
		cyc(20);
		rst_n <= 1'b1;
		cyc(2);
		rd(ADDR_CTRL, 32'h13, 1'b0);
		rd(ADDR_FMAX, 32'h64, 1'b0);
		rd(ADDR_HYST, 32'h0A, 1'b0);
		rd(8'h10, 32'h0, 1'b1);
		wr(ADDR_STATUS, 32'h1, 1'b1);
		wr(ADDR_FMAX, 32'h5, 1'b0);
		rd(ADDR_FMAX, 32'h0A, 1'b0);
		wr(ADDR_FMAX, 32'h2710, 1'b0);
		rd(ADDR_FMAX, 32'h26AC, 1'b0);
		wr(ADDR_HYST, 32'h3C, 1'b0);
		rd(ADDR_HYST, 32'h32, 1'b0);
		wr(ADDR_FMAX, 32'h64, 1'b0);
		wr(ADDR_HYST, 32'h0A, 1'b0);
		$display("test registers done");
		wr(ADDR_CTRL, 32'h1B, 1'b0);
		cyc(6);
		check(override_active, 1'b0, "level high at start");
		ssr_field_model_i.set_ovr(1'b0);
		cyc(6);
		ssr_field_model_i.set_ovr(1'b1);
		cyc(6);
		check(override_active, 1'b1, "bypass on rise");
		cyc(60);
		check(override_active, 1'b0, "time limit");
		ssr_field_model_i.set_ovr(1'b0);
		$display("test override start done");
		ssr_field_model_i.set_freq(20'd50, 1'b1);
		cyc(6);
		check(release_out, 1'b0, "no release before restart");
		count_blink(1'b0, n);
		check(n, 32'd10, "restart request blink");
		ssr_field_model_i.pulse(1'b0);
		cyc(8);
		check(release_out, 1'b1, "release after restart");
		check(restart_req, 1'b0, "restart request off");
		ssr_field_model_i.set_freq(20'd100, 1'b1);
		cyc(4);
		check(release_out, 1'b0, "withdraw at fmax");
		ssr_field_model_i.set_freq(20'd95, 1'b1);
		cyc(8);
		check(release_out, 1'b0, "hysteresis band");
		wr(ADDR_CTRL, 32'h1A, 1'b0);
		ssr_field_model_i.set_freq(20'd89, 1'b1);
		cyc(6);
		check(release_out, 1'b1, "automatic release");
		$display("test restart and threshold done");
		warn_vib_in <= 1'b1;
		warn_phase_in <= 1'b1;
		cyc(3);
		check({warn_vib, warn_phase}, 2'b11, "warnings on");
		warn_vib_in <= 1'b0;
		warn_phase_in <= 1'b0;
		cyc(3);
		check({warn_vib, warn_phase}, 2'b00, "warnings clear");
		ssr_field_model_i.set_freq(20'd50, 1'b0);
		cyc(4);
		check(release_out, 1'b0, "no valid data");
		ssr_field_model_i.set_freq(20'd50, 1'b1);
		cyc(8);
		ssr_field_model_i.set_ovr(1'b1);
		cyc(6);
		ssr_field_model_i.err_pulse('{cutoff: 1'b1, sensor: 1'b0, disc: 1'b0});
		cyc(4);
		check(err_flags, 3'b100, "cutoff flag");
		check(release_out, 1'b1, "release kept by bypass");
		ssr_field_model_i.pulse(1'b1);
		cyc(8);
		check({override_active, err_flags}, 4'b1000, "reset in bypass");
		ssr_field_model_i.err_pulse('{cutoff: 1'b0, sensor: 1'b1, disc: 1'b0});
		cyc(4);
		check(err_flags, 3'b010, "sensor flag");
		ssr_field_model_i.set_ovr(1'b0);
		cyc(8);
		check({override_active, err_flags}, 4'b0000, "bypass end clears");
		check(release_out, 1'b1, "release re-evaluated");
		$display("test bypass errors done");
		ssr_field_model_i.err_pulse('{cutoff: 1'b0, sensor: 1'b0, disc: 1'b1});
		cyc(4);
		check({release_out, err_flags}, 4'b0001, "safe state");
		rd(ADDR_STATUS, 32'h14, 1'b0);
		count_blink(1'b1, n);
		check(n, 32'd10, "reset request blink");
		ssr_field_model_i.pulse(1'b1);
		cyc(8);
		check({reset_req, err_flags}, 4'b0000, "full reset");
		$display("test error reset done");
		wr(ADDR_CTRL, 32'h16, 1'b0);
		ssr_field_model_i.set_freq(20'd100, 1'b1);
		cyc(4);
		ssr_field_model_i.set_ovr(1'b1);
		cyc(8);
		check(override_active, 1'b0, "mute needs release");
		ssr_field_model_i.set_ovr(1'b0);
		ssr_field_model_i.set_freq(20'd50, 1'b1);
		cyc(8);
		ssr_field_model_i.set_ovr(1'b1);
		cyc(8);
		check(override_active, 1'b1, "mute while released");
		ssr_field_model_i.set_ovr(1'b0);
		cyc(8);
		check(override_active, 1'b0, "mute ends on fall");
		$display("test mute done");
		wr(ADDR_CTRL, 32'h32, 1'b0);
		ssr_field_model_i.err_pulse('{cutoff: 1'b0, sensor: 1'b0, disc: 1'b1});
		ssr_field_model_i.pulse(1'b1);
		cyc(8);
		check({release_out, err_flags}, 4'b0001, "short reset ignored");
		ssr_field_model_i.set_ovr(1'b1);
		cyc(8);
		check(override_active, 1'b0, "override mode off");
		$display("test config modes done");
		finish_test();
	end
endmodule // tb_ssr_monitor
